// *** src/edge_sync.sv ***
// two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
module edge_sync
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
endmodule : edge_sync

// *** src/timer16.sv ***
// sixteen bit timer/counter with control, count and interrupt registers
// Function
// - control bit 0 runs the counter when set, halts it when clear.
// - control bit 7 selects buffered 16-bit access, else two 8-bit accesses.
// - control bit 6 is read-only, zero at reset, shows system clock from oscillator.
// - control bit 3 enables the dedicated low-power oscillator.
// - count appears as low and high bytes, both readable and writable.
// - software picks internal instruction clock or external/oscillator clock source.
// - special event trigger from compare/capture unit zeroes the count.
// - counter is always one 16-bit timer or counter, no 8-bit mode.
// - source clear counts instruction cycles at clock/4; set counts external pin rises, or oscillator rises when bit 3 is set.
// - wide mode low-byte read copies live high byte into high buffer.
// - wide mode high writes hit buffer; low write loads both bytes.
// - low-byte writes clear the prescaler; high-byte writes leave it.
`timescale 1ns/1ps
module timer16
  import timer_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ext_clock_in,
  input wire logic aux_osc_clock,
  input wire logic sysclk_from_aux_osc,
  input wire logic special_event,
  output logic aux_osc_enable,
  output logic overflow_pulse,
  output logic irq
);
  // byte lanes and the wrap compare are fixed at two bytes
  if (COUNT_W != 16) begin : g_width_check
    $error("timer16 supports only a 16-bit count");
  end

  logic rst_a_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  logic ext_rise;
  logic osc_rise;
  logic sys_level;
  logic evt_rise;
  edge_sync u_ext (.clock(clock), .rst_n(rst_n), .din(ext_clock_in), .level(),
    .rise(ext_rise));
  edge_sync u_osc (.clock(clock), .rst_n(rst_n), .din(aux_osc_clock), .level(),
    .rise(osc_rise));
  edge_sync u_sys (.clock(clock), .rst_n(rst_n), .din(sysclk_from_aux_osc), .level(sys_level),
    .rise());
  edge_sync u_evt (.clock(clock), .rst_n(rst_n), .din(special_event), .level(),
    .rise(evt_rise));

  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] high_buf_reg;
  logic [7:0] high_buf_next;
  logic [2:0] ps_reg;
  logic [2:0] ps_next;
  logic [1:0] instr_reg;
  logic [1:0] instr_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ovf_reg;
  logic ovf_next;

  // prescale terminal value for a 2-bit select
  function automatic logic [2:0] ps_last(input logic [1:0] sel);
    ps_last = 3'((4'h1 << sel) - 4'h1);
  endfunction : ps_last

  logic wide;
  logic run;
  logic tick_src;
  logic tick;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic [1:0] events;
  assign wide = control_reg[BIT_WIDE];
  assign run = control_reg[BIT_RUN];
  assign wr_low = wr_en && (addr == OFF_COUNT_LOW);
  assign wr_high = wr_en && (addr == OFF_COUNT_HIGH);
  assign rd_low = rd_en && (addr == OFF_COUNT_LOW);

  always_comb begin
    if (!control_reg[BIT_SRC]) begin
      tick_src = (instr_reg == INSTR_LAST);
    end else if (control_reg[BIT_OSC_EN]) begin
      tick_src = osc_rise;
    end else begin
      tick_src = ext_rise;
    end
  end

  assign tick = run && tick_src && (ps_reg == ps_last(control_reg[BIT_PS_LO+1 -: 2]));

  always_comb begin
    instr_next = 2'(instr_reg + 2'h1);
    ps_next = ps_reg;
    if (run && tick_src) begin
      ps_next = tick ? PS_RESET : 3'(ps_reg + 3'h1);
    end
    if (wr_low) begin
      ps_next = PS_RESET;
    end
  end

  // count path
  always_comb begin
    count_next = count_reg;
    high_buf_next = high_buf_reg;
    ovf_next = 1'b0;
    if (tick) begin
      count_next = 16'(count_reg + 16'h0001);
      ovf_next = (count_reg == 16'hffff);
    end
    if (rd_low && wide) begin
      high_buf_next = count_reg[15:8];
    end
    if (wr_high) begin
      if (wide) begin
        high_buf_next = wdata;
      end else begin
        count_next[15:8] = wdata;
        ovf_next = 1'b0;
      end
    end
    if (wr_low) begin
      ovf_next = 1'b0;
      count_next[7:0] = wdata;
      if (wide) begin
        count_next[15:8] = high_buf_reg;
      end
    end
    if (evt_rise) begin
      count_next = COUNT_RESET;
      ovf_next = 1'b0;
    end
  end

  assign events = {evt_rise, ovf_reg};

  // registers and irq bookkeeping
  always_comb begin
    control_next = control_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (wr_en && addr == OFF_CONTROL) begin
      control_next = (wdata & CONTROL_WMASK) | (control_reg & ~CONTROL_WMASK);
    end
    control_next[BIT_SYSCLK] = sys_level;
    if (wr_en && addr == OFF_IRQ_MASK) begin
      mask_next = wdata[1:0];
    end
    if (wr_en && addr == OFF_IRQ_STATUS) begin
      status_next = status_reg & ~wdata[1:0];
    end
    // set beats a same-cycle clear
    status_next = status_next | events;
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      if (addr == OFF_CONTROL) begin
        rdata_next = control_reg;
      end else if (addr == OFF_COUNT_LOW) begin
        rdata_next = count_reg[7:0];
      end else if (addr == OFF_COUNT_HIGH) begin
        rdata_next = wide ? high_buf_reg : count_reg[15:8];
      end else if (addr == OFF_IRQ_STATUS) begin
        rdata_next = {6'h00, status_reg};
      end else if (addr == OFF_IRQ_MASK) begin
        rdata_next = {6'h00, mask_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET;
      count_reg <= COUNT_RESET;
      high_buf_reg <= 8'h00;
      ps_reg <= PS_RESET;
      instr_reg <= 2'h0;
      status_reg <= 2'h0;
      mask_reg <= 2'h0;
      rdata_reg <= 8'h00;
      ovf_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      count_reg <= count_next;
      high_buf_reg <= high_buf_next;
      ps_reg <= ps_next;
      instr_reg <= instr_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      ovf_reg <= ovf_next;
    end
  end

  assign rdata = rdata_reg;
  assign aux_osc_enable = control_reg[BIT_OSC_EN];
  assign overflow_pulse = ovf_reg;
  assign irq = |(status_reg & mask_reg);

  sequence low_write_s;
    wr_en && addr == OFF_COUNT_LOW;
  endsequence

  halt_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !run && !wr_en && !evt_rise |=> count_reg == $past(count_reg))
    else $error("count moved while halted");
  wide_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    low_write_s and wide && !evt_rise |=> count_reg == {$past(high_buf_reg), $past(wdata)})
    else $error("wide low write did not load both bytes");
  high_buf_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_high && wide && !evt_rise && !tick |=> count_reg == $past(count_reg))
    else $error("wide high write reached the count");
  snap_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd_low && wide && !wr_high |=> high_buf_reg == $past(count_reg[15:8]))
    else $error("high buffer not captured");
  sysclk_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
    control_reg[BIT_SYSCLK] == $past(sys_level))
    else $error("system clock flag not tracking");
  osc_en_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en && addr == OFF_CONTROL |=> aux_osc_enable == $past(wdata[BIT_OSC_EN]))
    else $error("oscillator enable not written");
  ps_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    low_write_s |=> ps_reg == PS_RESET)
    else $error("prescaler not cleared");
  event_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    evt_rise |=> count_reg == COUNT_RESET)
    else $error("special event did not clear count");
  wrap_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && count_reg == 16'hffff && !wr_en && !evt_rise |=> ovf_reg ##1 status_reg[IRQ_OVF])
    else $error("overflow flag missing");
  instr_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    run && !control_reg[BIT_SRC] && control_reg[5:4] == 2'h0 && !wr_en && !evt_rise
    && instr_reg == 2'h0 |=> count_reg == $past(count_reg))
    else $error("count moved off instruction boundary");
endmodule : timer16

// *** src/timer_pkg.sv ***
// constants for the sixteen bit timer/counter block
package timer_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h1;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h2;
  localparam logic [2:0] OFF_IRQ_STATUS = 3'h3;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h4;
  localparam int BIT_RUN = 0;
  localparam int BIT_SRC = 1;
  localparam int BIT_SYNC_N = 2;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_SYSCLK = 6;
  localparam int BIT_WIDE = 7;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EVENT = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hbf;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'h3;
endpackage : timer_pkg

// *** tb/timer16_tb_top.sv ***
// self-checking bench for the sixteen bit timer/counter block
`timescale 1ns/1ps
`define chk(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module timer16_tb_top;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic ext_clock_in = 1'b0;
  logic aux_osc_clock = 1'b0;
  logic sysclk_from_aux_osc = 1'b0;
  logic special_event = 1'b0;
  logic aux_osc_enable;
  logic overflow_pulse;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;
  int ovf_seen = 0;
  integer seed = 15;
  logic [7:0] r1, r2, r3, r4, d;
  logic [15:0] cnt;
  int n, expect_cnt;

  timer16 dut_u (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ext_clock_in(ext_clock_in), .aux_osc_clock(aux_osc_clock),
    .sysclk_from_aux_osc(sysclk_from_aux_osc), .special_event(special_event),
    .aux_osc_enable(aux_osc_enable), .overflow_pulse(overflow_pulse), .irq(irq));

  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (overflow_pulse === 1'b1) begin
      ovf_seen++;
    end
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // low first, so wide mode latches the matching high byte
  task automatic wide_access_mode(output logic [15:0] v);
    rd(OFF_COUNT_LOW, v[7:0]);
    rd(OFF_COUNT_HIGH, v[15:8]);
  endtask : wide_access_mode

  task automatic load16(input logic [15:0] v);
    wr(OFF_COUNT_HIGH, v[15:8]);
    wr(OFF_COUNT_LOW, v[7:0]);
  endtask : load16

  // k selects pin or oscillator; slow edges so the synchroniser sees each one
  task automatic pulses(input int k, input int cnt_n);
    for (int i = 0; i < cnt_n; i++) begin
      @(posedge clock);
      if (k == 0) begin
        ext_clock_in <= 1'b1;
      end else begin
        aux_osc_clock <= 1'b1;
      end
      repeat (3) @(posedge clock);
      if (k == 0) begin
        ext_clock_in <= 1'b0;
      end else begin
        aux_osc_clock <= 1'b0;
      end
      repeat (3) @(posedge clock);
    end
  endtask : pulses

  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFF_CONTROL, d); `chk(d, CONTROL_RESET)
    wr(OFF_CONTROL, 8'hff);
    rd(OFF_CONTROL, d); `chk(d, 8'hbf)
    `chk(aux_osc_enable, 1'b1)
    sysclk_from_aux_osc <= 1'b1;
    repeat (5) @(posedge clock);
    rd(OFF_CONTROL, d); `chk(d, 8'hff)
    sysclk_from_aux_osc <= 1'b0;
    wr(OFF_CONTROL, 8'h00);
    #1 `chk(aux_osc_enable, 1'b0)
    rd(3'h5, d); `chk(d, 8'h00)
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    r3 = r1 ^ 8'h5a;
    r4 = 8'($random(seed));
    load16({r1, r2});
    rd(OFF_COUNT_LOW, d); `chk(d, r2)
    rd(OFF_COUNT_HIGH, d); `chk(d, r1)
    // wide mode high write only buffered
    wr(OFF_CONTROL, 8'h80);
    wr(OFF_COUNT_HIGH, r3);
    rd(OFF_COUNT_LOW, d); `chk(d, r2)
    rd(OFF_COUNT_HIGH, d); `chk(d, r1)
    load16({r3, r4});
    wide_access_mode(cnt); `chk(cnt, {r3, r4})
    // every prescale code, low write clears prescaler
    for (int ps = 0; ps < 4; ps++) begin
      load16(16'h0000);
      wr(OFF_CONTROL, 8'h81 | 8'(ps << 4));
      repeat (254) @(posedge clock);
      wr(OFF_CONTROL, 8'h80);
      wide_access_mode(cnt);
      expect_cnt = 256 / (INSTR_DIV << ps);
      `chk(int'(cnt) >= expect_cnt - 1 && int'(cnt) <= expect_cnt + 1, 1'b1)
    end
    // rollover while masked, then unmask and clear
    wr(OFF_IRQ_MASK, 8'h00);
    load16(16'hfffe);
    wr(OFF_CONTROL, 8'h81);
    repeat (40) @(posedge clock);
    wr(OFF_CONTROL, 8'h80);
    `chk(irq, 1'b0)
    `chk(ovf_seen, 1)
    rd(OFF_IRQ_STATUS, d); `chk(d, 8'h01)
    wr(OFF_IRQ_MASK, 8'h01);
    #1 `chk(irq, 1'b1)
    wr(OFF_IRQ_STATUS, 8'h01);
    #1 `chk(irq, 1'b0)
    for (int k = 0; k < 2; k++) begin
      n = 1 + ($unsigned($random(seed)) % 15);
      load16(16'h0000);
      wr(OFF_CONTROL, k == 0 ? 8'h83 : 8'h8b);
      pulses(k, n);
      repeat (4) @(posedge clock);
      wr(OFF_CONTROL, 8'h80);
      wide_access_mode(cnt); `chk(cnt, 16'(n))
    end
    pulses(0, 3);
    wide_access_mode(cnt); `chk(cnt, 16'(n))
    // special event zeroes a nonzero count
    wr(OFF_IRQ_MASK, 8'h02);
    special_event <= 1'b1;
    repeat (3) @(posedge clock);
    special_event <= 1'b0;
    repeat (5) @(posedge clock);
    `chk(irq, 1'b1)
    wide_access_mode(cnt); `chk(cnt, 16'h0000)
    rd(OFF_IRQ_STATUS, d); `chk(d, 8'h02)
    tally_and_finish();
  end

  // hang guard, well past the longest sequence
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule : timer16_tb_top
